// ==== verilog/addr_decode_cfg.svh ====
// Constants for the addressing-mode decoder
`ifndef ADDR_DECODE_CFG_SVH
`define ADDR_DECODE_CFG_SVH
`define PAGE_RESET      8'h00
`define LEN_ONE         2'h1
`define LEN_TWO         2'h2
`define LEN_THREE       2'h3
`define BRANCH_BIAS     16'h0002
`define OPND_STEP       16'h0001
`define HI_BITSET       4'h1
`define HI_BITTEST      4'h0
`define HI_REL          4'h2
`define HI_RMW_DIR      4'h3
`define HI_RMW_A        4'h4
`define HI_RMW_X        4'h5
`define HI_RMW_IX1      4'h6
`define HI_RMW_IX0      4'h7
`define HI_CTL_A        4'h8
`define HI_CTL_B        4'h9
`define HI_IMM          4'ha
`define HI_DIR          4'hb
`define HI_EXT          4'hc
`define HI_IX2          4'hd
`define HI_IX1          4'he
`define HI_IX0          4'hf
`define LO_TEST         4'hd
`define LO_JMP          4'hc
`define LO_JSR          4'hd
`define LO_STORE_A      4'h7
`define LO_STORE_X      4'hf
`define LO_BSR          4'hd
`define LO_MUL          4'h2
`endif

// ==== verilog/addr_decode_pkg.sv ====
// Types shared by the addressing-mode decoder
package addr_decode_pkg;
	typedef enum logic [3:0] {
		MODE_IMPLIED  = 4'h0,
		MODE_IMM      = 4'h1,
		MODE_DIR      = 4'h2,
		MODE_EXT      = 4'h3,
		MODE_REL      = 4'h4,
		MODE_IX0      = 4'h5,
		MODE_IX1      = 4'h6,
		MODE_IX2      = 4'h7,
		MODE_BITSET   = 4'h8,
		MODE_BITTEST  = 4'h9
	} mode_t;
	typedef enum logic [2:0] {
		CLASS_REGMEM  = 3'h0,
		CLASS_RMW     = 3'h1,
		CLASS_BRANCH  = 3'h2,
		CLASS_BITMAN  = 3'h3,
		CLASS_CONTROL = 3'h4
	} iclass_t;
	// Instruction bytes and core state presented for decoding
	typedef struct packed {
		logic [7:0]  opcode;
		logic [7:0]  byte2;
		logic [7:0]  byte3;
		logic [15:0] pc;
		logic [7:0]  index;
		logic        cond_true;
		logic [7:0]  mem_data;
	} instr_t;
	// Decoded result
	typedef struct packed {
		mode_t       mode;
		iclass_t     iclass;
		logic [1:0]  length;
		logic [15:0] effective_addr;
		logic        addr_valid;
		logic        mem_read;
		logic        mem_write;
		logic        uses_reg;
		logic        is_jump;
		logic [2:0]  bit_sel;
		logic        bit_value;
		logic        branch_taken;
		logic [15:0] next_pc;
	} decode_t;
endpackage

// ==== verilog/mode_lookup.sv ====
// Opcode to addressing mode, class and length lookup
`timescale 1ns/100ps
`include "addr_decode_cfg.svh"
module mode_lookup
	import addr_decode_pkg::*;
(
	input  wire logic [7:0]               opcode,
	output addr_decode_pkg::mode_t        mode,
	output addr_decode_pkg::iclass_t      iclass,
	output logic      [1:0]               length
);
	import addr_decode_pkg::*;
	wire [3:0] hi = opcode[7:4];
	wire [3:0] lo = opcode[3:0];
	// Mode from the high nibble of the opcode; the low nibble only picks out BSR in the immediate column
	always_comb
	begin
		case (hi)
			`HI_BITTEST: mode = MODE_BITTEST;
			`HI_BITSET:  mode = MODE_BITSET;
			`HI_REL:     mode = MODE_REL;
			`HI_RMW_DIR: mode = MODE_DIR;
			`HI_RMW_IX1: mode = MODE_IX1;
			`HI_RMW_IX0: mode = MODE_IX0;
			`HI_IMM:     mode = (lo == `LO_BSR) ? MODE_REL : MODE_IMM;
			`HI_DIR:     mode = MODE_DIR;
			`HI_EXT:     mode = MODE_EXT;
			`HI_IX2:     mode = MODE_IX2;
			`HI_IX1:     mode = MODE_IX1;
			`HI_IX0:     mode = MODE_IX0;
			default:     mode = MODE_IMPLIED;
		endcase
	end
	// Class from the high nibble
	always_comb
	begin
		case (hi)
			`HI_BITTEST, `HI_BITSET: iclass = CLASS_BITMAN;
			`HI_REL: iclass = CLASS_BRANCH;
			`HI_RMW_DIR, `HI_RMW_A, `HI_RMW_X, `HI_RMW_IX1, `HI_RMW_IX0:
				iclass = CLASS_RMW;
			`HI_CTL_A, `HI_CTL_B: iclass = CLASS_CONTROL;
			default: iclass = CLASS_REGMEM;
		endcase
	end
	// Byte count per mode
	always_comb
	begin
		case (mode)
			MODE_IMPLIED, MODE_IX0: length = `LEN_ONE;
			MODE_IMM, MODE_DIR, MODE_REL, MODE_IX1, MODE_BITSET:
				length = `LEN_TWO;
			MODE_EXT, MODE_IX2, MODE_BITTEST: length = `LEN_THREE;
			default: length = `LEN_ONE;
		endcase
	end
endmodule

// ==== verilog/page_select.sv ====
// Page-select register for direct and bit addressing
`timescale 1ns/100ps
`include "addr_decode_cfg.svh"
module page_select
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       page_wr,
	input  wire logic [7:0] page_wdata,
	output logic      [7:0] page_select_reg
);
	// Cleared at reset, loaded by software
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			page_select_reg <= `PAGE_RESET;
		else if (page_wr)
			page_select_reg <= page_wdata;
	end
endmodule

// ==== verilog/addr_decode.sv ====
// Effective-address generation and instruction-class decode
`timescale 1ns/100ps
`include "addr_decode_cfg.svh"
module addr_decode
	import addr_decode_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     start,
	input  addr_decode_pkg::instr_t       instr,
	input  wire logic                     page_wr,
	input  wire logic [7:0]               page_wdata,
	output addr_decode_pkg::decode_t      result,
	output logic                          result_valid,
	output logic                          carry_wr,
	output logic                          carry_value,
	output logic      [7:0]               page_value
);
	import addr_decode_pkg::*;

	// Bit select from the low opcode bits, shared by both bit forms
	function automatic logic [2:0] bit_of(input logic [7:0] op);
		bit_of = op[3:1];
	endfunction

	mode_t      mode;
	iclass_t    iclass;
	logic [1:0] length;
	logic [7:0] page_select_reg;

	mode_lookup u_lookup
	(
		.opcode (instr.opcode),
		.mode   (mode),
		.iclass (iclass),
		.length (length)
	);

	page_select u_page
	(
		.clk             (clk),
		.rst_n           (rst_n),
		.page_wr         (page_wr),
		.page_wdata      (page_wdata),
		.page_select_reg (page_select_reg)
	);

	// Address arithmetic, all modulo 16 bits; the index is only read
	wire [15:0] word_operand = {instr.byte2, instr.byte3};
	wire [15:0] ix_ext       = {8'h00, instr.index};
	wire [15:0] paged_addr   = {page_select_reg, instr.byte2};
	wire [15:0] ix1_addr     = ix_ext + {8'h00, instr.byte2};
	wire [15:0] ix2_addr     = ix_ext + word_operand;
	wire [15:0] opnd_pc      = instr.pc + `OPND_STEP;
	wire [15:0] seq_pc       = instr.pc + {14'h0000, length};

	// Bit test on the fetched byte; even opcodes branch on set
	wire [2:0]  bit_sel      = bit_of(instr.opcode);
	wire        tested_bit   = instr.mem_data[bit_sel];
	wire        test_hit     = instr.opcode[0] ? ~tested_bit : tested_bit;
	wire        is_bittest   = (mode == MODE_BITTEST);
	wire        is_rel       = (mode == MODE_REL);
	wire        taken        = is_bittest ? test_hit : (is_rel & instr.cond_true);
	wire [7:0]  disp         = is_bittest ? instr.byte3 : instr.byte2;
	wire [7:0]  rel_eff      = taken ? disp : 8'h00;
	wire [15:0] rel_ext      = {{8{rel_eff[7]}}, rel_eff};
	wire [15:0] branch_pc    = instr.pc + {14'h0000, length} + rel_ext;
	wire [15:0] rel_pc       = instr.pc + `BRANCH_BIAS + rel_ext;

	wire [3:0]  lo           = instr.opcode[3:0];
	wire [3:0]  hi           = instr.opcode[7:4];
	wire        is_regmem    = (iclass == CLASS_REGMEM);
	wire        is_jmp       = is_regmem & (lo == `LO_JMP);
	wire        is_jsr       = is_regmem & (lo == `LO_JSR) & (hi != `HI_IMM);
	wire        is_store     = is_regmem & ((lo == `LO_STORE_A) | (lo == `LO_STORE_X));
	wire        is_test      = (iclass == CLASS_RMW) & (lo == `LO_TEST);
	wire        rmw_mem      = (iclass == CLASS_RMW) & (mode != MODE_IMPLIED);

	// Effective address per mode
	logic [15:0] ea;
	logic        ea_valid;
	always_comb
	begin
		ea_valid = 1'b1;
		case (mode)
			MODE_IMM:     ea = opnd_pc;
			MODE_DIR:     ea = paged_addr;
			MODE_EXT:     ea = word_operand;
			MODE_REL:     ea = rel_pc;
			MODE_IX0:     ea = ix_ext;
			MODE_IX1:     ea = ix1_addr;
			MODE_IX2:     ea = ix2_addr;
			MODE_BITSET:  ea = paged_addr;
			MODE_BITTEST: ea = paged_addr;
			MODE_IMPLIED:
			begin
				ea = 16'h0000;
				ea_valid = 1'b0;
			end
			default:
			begin
				ea = 16'h0000;
				ea_valid = 1'b0;
			end
		endcase
	end

	// Memory access intent per class
	wire mem_mode  = ea_valid & ~is_rel & (mode != MODE_IMM);
	wire next_read = (is_regmem & mem_mode & ~is_jmp & ~is_jsr & ~is_store)
		| rmw_mem | (mode == MODE_BITSET) | is_bittest;
	wire next_write = (is_regmem & mem_mode & is_store)
		| (rmw_mem & ~is_test)
		| (mode == MODE_BITSET);
	wire uses_reg  = (is_regmem & ~is_jmp & ~is_jsr)
		| ((iclass == CLASS_RMW) & ~rmw_mem);
	wire flow_jump = is_jmp | is_jsr;
	wire [15:0] next_flow = flow_jump ? ea : ((is_rel | is_bittest) ? branch_pc : seq_pc);

	// Assemble the decoded record
	decode_t next_result;
	always_comb
	begin
		next_result.mode           = mode;
		next_result.iclass         = iclass;
		next_result.length         = length;
		next_result.effective_addr = ea;
		next_result.addr_valid     = ea_valid;
		next_result.mem_read       = next_read;
		next_result.mem_write      = next_write;
		next_result.uses_reg       = uses_reg;
		next_result.is_jump        = flow_jump;
		next_result.bit_sel        = bit_sel;
		next_result.bit_value      = ~instr.opcode[0];
		next_result.branch_taken   = taken;
		next_result.next_pc        = next_flow;
	end

	// Registered outputs
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			result       <= '0;
			result_valid <= 1'b0;
			carry_wr     <= 1'b0;
			carry_value  <= 1'b0;
			page_value   <= `PAGE_RESET;
		end
		else
		begin
			result       <= next_result;
			result_valid <= start;
			carry_wr     <= start & is_bittest;
			carry_value  <= tested_bit;
			page_value   <= page_select_reg;
		end
	end

	// Checks
	property p_page_reset;
		@(posedge clk) !rst_n |=> (page_value == 8'h00) or !rst_n;
	endproperty
	a_page_reset: assert property (p_page_reset) else $error("page not cleared");

	property p_imm_ea;
		@(posedge clk) disable iff (!rst_n)
		(start && mode == MODE_IMM) |=> result.effective_addr == $past(instr.pc) + 16'h0001
			&& result.length == 2'h2;
	endproperty
	a_imm_ea: assert property (p_imm_ea) else $error("immediate address wrong");

	property p_dir_ea;
		@(posedge clk) disable iff (!rst_n)
		(start && mode == MODE_DIR) |=>
			result.effective_addr == {$past(page_select_reg), $past(instr.byte2)};
	endproperty
	a_dir_ea: assert property (p_dir_ea) else $error("direct address wrong");

	property p_ext_ea;
		@(posedge clk) disable iff (!rst_n)
		(start && mode == MODE_EXT) |=> result.length == 2'h3
			&& result.effective_addr == {$past(instr.byte2), $past(instr.byte3)};
	endproperty
	a_ext_ea: assert property (p_ext_ea) else $error("extended address wrong");

	property p_rel_nt;
		@(posedge clk) disable iff (!rst_n)
		(start && is_rel && !instr.cond_true) |=>
			result.next_pc == $past(instr.pc) + 16'h0002 && !result.branch_taken;
	endproperty
	a_rel_nt: assert property (p_rel_nt) else $error("untaken branch moved");

	property p_ix0;
		@(posedge clk) disable iff (!rst_n)
		(start && mode == MODE_IX0) |=> result.effective_addr[15:8] == 8'h00
			&& result.length == 2'h1;
	endproperty
	a_ix0: assert property (p_ix0) else $error("index reach wrong");

	// Bit-test issue, shared by the carry and bit-test target checks
	sequence s_bittest_start;
		start && is_bittest;
	endsequence

	property p_carry;
		@(posedge clk) disable iff (!rst_n)
		s_bittest_start |=> carry_wr
			&& (carry_value == (result.branch_taken ^ $past(instr.opcode[0])));
	endproperty
	a_carry: assert property (p_carry) else $error("carry not updated");

	property p_test_nowrite;
		@(posedge clk) disable iff (!rst_n)
		(start && is_test) |=> !result.mem_write;
	endproperty
	a_test_nowrite: assert property (p_test_nowrite) else $error("test wrote back");

	property p_jump_noreg;
		@(posedge clk) disable iff (!rst_n)
		(start && flow_jump) |=> !result.uses_reg && result.next_pc == result.effective_addr;
	endproperty
	a_jump_noreg: assert property (p_jump_noreg) else $error("jump used register");

	property p_implied;
		@(posedge clk) disable iff (!rst_n)
		(start && mode == MODE_IMPLIED) |=> !result.addr_valid && result.length == 2'h1;
	endproperty
	a_implied: assert property (p_implied) else $error("implied formed address");

	// Relative branch issued with its condition true
	sequence s_rel_taken;
		start && is_rel && instr.cond_true;
	endsequence

	property p_rel_taken;
		@(posedge clk) disable iff (!rst_n)
		s_rel_taken |=> result.branch_taken && result.next_pc == $past(instr.pc)
			+ `BRANCH_BIAS + {{8{$past(instr.byte2[7])}}, $past(instr.byte2)};
	endproperty
	a_rel_taken: assert property (p_rel_taken) else $error("branch target wrong");

	property p_bittest_ea;
		@(posedge clk) disable iff (!rst_n)
		s_bittest_start |=> result.length == `LEN_THREE
			&& result.effective_addr == {$past(page_select_reg), $past(instr.byte2)};
	endproperty
	a_bittest_ea: assert property (p_bittest_ea) else $error("bit address wrong");

	property p_bittest_pc;
		@(posedge clk) disable iff (!rst_n)
		s_bittest_start |=> result.next_pc == $past(instr.pc) + {14'h0000, `LEN_THREE}
			+ (result.branch_taken ? {{8{$past(instr.byte3[7])}}, $past(instr.byte3)}
			: 16'h0000);
	endproperty
	a_bittest_pc: assert property (p_bittest_pc) else $error("bit branch wrong");

	property p_ix1_ea;
		@(posedge clk) disable iff (!rst_n)
		(start && mode == MODE_IX1) |=> result.length == `LEN_TWO
			&& result.effective_addr
			== {8'h00, $past(instr.index)} + {8'h00, $past(instr.byte2)};
	endproperty
	a_ix1_ea: assert property (p_ix1_ea) else $error("byte index address wrong");

	property p_ix2_ea;
		@(posedge clk) disable iff (!rst_n)
		(start && mode == MODE_IX2) |=> result.length == `LEN_THREE
			&& result.effective_addr
			== {8'h00, $past(instr.index)} + {$past(instr.byte2), $past(instr.byte3)};
	endproperty
	a_ix2_ea: assert property (p_ix2_ea) else $error("word index address wrong");

	property p_bitset;
		@(posedge clk) disable iff (!rst_n)
		(start && mode == MODE_BITSET) |=> result.bit_sel == $past(instr.opcode[3:1])
			&& result.bit_value == !$past(instr.opcode[0])
			&& result.effective_addr == {$past(page_select_reg), $past(instr.byte2)};
	endproperty
	a_bitset: assert property (p_bitset) else $error("bit set decode wrong");

	property p_rmw_back;
		@(posedge clk) disable iff (!rst_n)
		(start && rmw_mem && !is_test) |=> result.mem_read && result.mem_write;
	endproperty
	a_rmw_back: assert property (p_rmw_back) else $error("modify not stored back");

	property p_regmem_read;
		@(posedge clk) disable iff (!rst_n)
		(start && is_regmem && mem_mode && !flow_jump && !is_store)
			|=> result.mem_read && result.uses_reg && !result.mem_write;
	endproperty
	a_regmem_read: assert property (p_regmem_read) else $error("operand not read");

	property p_carry_quiet;
		@(posedge clk) disable iff (!rst_n)
		!(start && is_bittest) |=> !carry_wr;
	endproperty
	a_carry_quiet: assert property (p_carry_quiet) else $error("stray carry write");

	property p_page_track;
		@(posedge clk) disable iff (!rst_n)
		page_wr |=> page_select_reg == $past(page_wdata);
	endproperty
	a_page_track: assert property (p_page_track) else $error("page write lost");
endmodule

// ==== tb/mem_model.sv ====
// Behavioural data memory that answers the tested-byte read
`timescale 1ns/100ps
module mem_model
(
	input  wire logic [15:0] addr,
	output logic      [7:0]  data
);
	// Contents depend on both address bytes, so a wrong page shows up
	assign data = addr[7:0] ^ addr[15:8] ^ 8'h5a;
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the addressing-mode decoder
`timescale 1ns/100ps
module tb;
	import addr_decode_pkg::*;
	typedef struct packed {
		logic [7:0]  op;
		logic [7:0]  b2;
		logic [7:0]  b3;
		logic [7:0]  ix;
		mode_t       md;
		logic [1:0]  ln;
		logic [15:0] ea;
		logic        rd;
		logic        wr;
		logic        ce;
		logic        cm;
	} row_t;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        start = 1'b0;
	logic        page_wr = 1'b0;
	logic [7:0]  page_wdata = 8'h00;
	logic [7:0]  pg = 8'h00;
	instr_t      instr = '0;
	decode_t     result;
	logic        result_valid;
	logic        carry_wr;
	logic        carry_value;
	logic [7:0]  page_value;
	logic [7:0]  mdata;
	logic [7:0]  op;
	logic [7:0]  d;
	logic        b;
	logic [7:0]  mb;
	logic [15:0] xp;
	instr_t      dut_instr;
	int          error_cnt = 0;
	int          n_compared = 0;
	// Ordinary cases: opcode bytes and index beside the decode they should give
	row_t rows [12] = '{
		'{8'ha6, 8'h11, 8'h00, 8'h00, MODE_IMM, 2'h2, 16'h1001, 1'b0, 1'b0, 1'b1, 1'b0},
		'{8'hb6, 8'h45, 8'h00, 8'h00, MODE_DIR, 2'h2, 16'h0045, 1'b1, 1'b0, 1'b1, 1'b1},
		'{8'hc6, 8'h12, 8'h34, 8'h00, MODE_EXT, 2'h3, 16'h1234, 1'b1, 1'b0, 1'b1, 1'b1},
		'{8'hc7, 8'h12, 8'h34, 8'h00, MODE_EXT, 2'h3, 16'h1234, 1'b0, 1'b1, 1'b1, 1'b1},
		'{8'hf6, 8'h00, 8'h00, 8'h80, MODE_IX0, 2'h1, 16'h0080, 1'b1, 1'b0, 1'b1, 1'b1},
		'{8'he6, 8'hff, 8'h00, 8'hff, MODE_IX1, 2'h2, 16'h01fe, 1'b1, 1'b0, 1'b1, 1'b1},
		'{8'hd6, 8'hff, 8'hff, 8'h02, MODE_IX2, 2'h3, 16'h0001, 1'b1, 1'b0, 1'b1, 1'b1},
		'{8'h3c, 8'h45, 8'h00, 8'h00, MODE_DIR, 2'h2, 16'h0045, 1'b1, 1'b1, 1'b1, 1'b1},
		'{8'h3d, 8'h45, 8'h00, 8'h00, MODE_DIR, 2'h2, 16'h0045, 1'b1, 1'b0, 1'b1, 1'b1},
		'{8'h7d, 8'h00, 8'h00, 8'h20, MODE_IX0, 2'h1, 16'h0020, 1'b1, 1'b0, 1'b1, 1'b1},
		'{8'h4c, 8'h00, 8'h00, 8'h00, MODE_IMPLIED, 2'h1, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1},
		'{8'h9d, 8'h00, 8'h00, 8'h00, MODE_IMPLIED, 2'h1, 16'h0000, 1'b0, 1'b0, 1'b0, 1'b1}
	};

	// Free-running clock
	always #20 clk = ~clk;

	mem_model mem_model_inst (.addr({pg, instr.byte2}), .data(mdata));

	// Tested byte comes straight from the memory model
	always_comb
	begin
		dut_instr          = instr;
		dut_instr.mem_data = mdata;
	end

	addr_decode addr_decode_inst (
		.clk          (clk),
		.rst_n        (rst_n),
		.start        (start),
		.instr        (dut_instr),
		.page_wr      (page_wr),
		.page_wdata   (page_wdata),
		.result       (result),
		.result_valid (result_valid),
		.carry_wr     (carry_wr),
		.carry_value  (carry_value),
		.page_value   (page_value)
	);

	// Compare one observed value with its expectation
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Present one instruction with start, then wait for its answer
	task automatic go(input logic [7:0] o, input logic [7:0] b2, input logic [7:0] b3,
			input logic [15:0] pc, input logic [7:0] ix, input logic ct);
		instr.opcode = o;
		instr.byte2 = b2;
		instr.byte3 = b3;
		instr.pc = pc;
		instr.index = ix;
		instr.cond_true = ct;
		start = 1'b1;
		@(negedge clk);
	endtask

	// Write a new page number and track it
	task automatic pw(input logic [7:0] v);
		start = 1'b0;
		page_wr = 1'b1;
		page_wdata = v;
		@(negedge clk);
		page_wr = 1'b0;
		pg = v;
	endtask

	function automatic logic [15:0] sx(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction

	// Instruction class from the column groups of the opcode map
	function automatic iclass_t cls(input logic [7:0] o);
		case (o[7:4])
			4'h0, 4'h1: return CLASS_BITMAN;
			4'h2: return CLASS_BRANCH;
			4'h3, 4'h4, 4'h5, 4'h6, 4'h7: return CLASS_RMW;
			4'h8, 4'h9: return CLASS_CONTROL;
			default: return CLASS_REGMEM;
		endcase
	endfunction

	// Print the counts and the verdict, then stop
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog against a hung run
	initial
	begin
		#20000;
		error_cnt++;
		summarize();
	end

	// Main sequence
	initial
	begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk("page_value", page_value, 16'h0000);
		chk("result_valid", result_valid, 16'h0000);
		// Table rows back to back
		foreach (rows[i])
		begin
			go(rows[i].op, rows[i].b2, rows[i].b3, 16'h1000, rows[i].ix, 1'b0);
			chk("result_valid", result_valid, 16'h0001);
			chk("mode", result.mode, rows[i].md);
			chk("length", result.length, rows[i].ln);
			chk("iclass", result.iclass, cls(rows[i].op));
			if (rows[i].ce)
				chk("ea", result.effective_addr, rows[i].ea);
			if (rows[i].cm)
			begin
				chk("mem_read", result.mem_read, rows[i].rd);
				chk("mem_write", result.mem_write, rows[i].wr);
			end
			if (rows[i].md == MODE_IMPLIED)
				chk("addr_valid", result.addr_valid, 16'h0000);
		end
		start = 1'b0;
		@(negedge clk);
		chk("result_valid", result_valid, 16'h0000);
		// Jumps against a register/memory load
		foreach (rows[i])
		begin
			op = (i == 0) ? 8'hcc : (i == 1) ? 8'hbd : 8'hc6;
			if (i < 3)
			begin
				go(op, 8'h12, 8'h34, 16'h1000, 8'h00, 1'b0);
				chk("is_jump", result.is_jump, op != 8'hc6);
				chk("uses_reg", result.uses_reg, op == 8'hc6);
				xp = (op == 8'hcc) ? 16'h1234 : (op == 8'hbd) ? 16'h0012 : 16'h1003;
				chk("next_pc", result.next_pc, xp);
			end
		end
		chk("ea", result.effective_addr, 16'h1234);
		// Every relative opcode, taken and not, across the displacement sign change
		for (int k = 0; k < 16; k++)
		begin
			d = 8'h78 + k[7:0];
			go(8'h20 + k[7:0], d, 8'h00, 16'h1000, 8'h00, k[0]);
			chk("mode", result.mode, MODE_REL);
			chk("length", result.length, 16'h0002);
			chk("taken", result.branch_taken, k[0]);
			chk("ea", result.effective_addr, k[0] ? 16'h1002 + sx(d) : 16'h1002);
			chk("next_pc", result.next_pc, k[0] ? 16'h1002 + sx(d) : 16'h1002);
			chk("iclass", result.iclass, CLASS_BRANCH);
		end
		// Subroutine branch decodes as relative, taken here
		go(8'had, 8'h10, 8'h00, 16'h1000, 8'h00, 1'b1);
		chk("mode", result.mode, MODE_REL);
		chk("next_pc", result.next_pc, 16'h1012);
		// Page moved, then every bit set and clear code
		pw(8'ha5);
		for (int k = 0; k < 16; k++)
		begin
			op = 8'h10 + k[7:0];
			go(op, 8'h33, 8'h00, 16'h1000, 8'h00, 1'b0);
			chk("page_value", page_value, 16'h00a5);
			chk("ea", result.effective_addr, 16'ha533);
			chk("bit_sel", result.bit_sel, op[3:1]);
			chk("bit_value", result.bit_value, !op[0]);
			chk("iclass", result.iclass, CLASS_BITMAN);
			chk("length", result.length, 16'h0002);
		end
		go(8'hb6, 8'h45, 8'h00, 16'h1000, 8'h00, 1'b0);
		chk("ea", result.effective_addr, 16'ha545);
		// Every bit test and branch code, reading the modelled memory
		for (int k = 0; k < 16; k++)
		begin
			op = k[7:0];
			d = 8'hf0 + 8'h11 * k[7:0];
			go(op, 8'h40 + op, d, 16'h2000, 8'h00, 1'b0);
			mb = (8'h40 + op) ^ pg ^ 8'h5a;
			b = mb[op[3:1]];
			chk("carry_wr", carry_wr, 16'h0001);
			chk("carry_value", carry_value, b);
			chk("taken", result.branch_taken, b ^ op[0]);
			chk("next_pc", result.next_pc, (b ^ op[0]) ? 16'h2003 + sx(d) : 16'h2003);
			chk("ea", result.effective_addr, {pg, 8'h40 + op});
			chk("length", result.length, 16'h0003);
			chk("iclass", result.iclass, CLASS_BITMAN);
		end
		start = 1'b0;
		@(negedge clk);
		chk("carry_wr", carry_wr, 16'h0000);
		// Second reset in mid-run returns the page to zero
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		pg = 8'h00;
		chk("page_value", page_value, 16'h0000);
		go(8'hb6, 8'h45, 8'h00, 16'h1000, 8'h00, 1'b0);
		chk("ea", result.effective_addr, 16'h0045);
		summarize();
	end
endmodule
